// [verilog/fas_frame_sieve.sv]
// Purpose: receive frame acquisition with history prediction and sieve memory
// Assumes: recovered serial data is synchronous to i_clock (the recovered bit clock)
// Notes:   history storage is written on the falling clock edge
// Contract
// - detect 00001111 as remote alarm pattern
// - gated alarm goes low at channel end
// - full alarm select passes raw detector
// - remote alarm register updates only in frame
// - history shifts up, new bit lowest
// - sixteen write pulses, states 0-3, gated
// - state 0 writes inverted data, then shifts
// - history decode gives superframe marker
// - history predicts next bit, else data
// - 24-channel compare gives match flag
// - write back predicted or inverted bit
// - states 0-3 fill sieve with ones
// - matching candidate clears its sieve bit
// - no candidate after 16 tries flags reset
// - mode selects preset, reload on load
// - low stages overflow advances high stage
// - carries make cycle enable and load enables
// - lowest counter stage addresses all memories
// - empty sieve clears cycle, delays load 16
// - cycle counter loads zero, eleven, advances
// - 16 and 256 count windows form gate
// - end of cycle is NAND with gate
// - frame-lock state zero, locks on candidate 15 at low overflow
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module fas_frame_sieve #(
  parameter int DEPTH = 16
) (
  input  wire logic              i_clock,
  input  wire logic              i_resetn,
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic      [31:0]       o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  input  wire logic              i_recovered_serial_data,
  input  wire logic              i_channel_timing_bus,
  output logic                   o_alarm_detect_n,
  output logic                   o_remote_alarm,
  output logic                   o_superframe_marker,
  output logic                   o_operational_gate,
  output logic                   o_end_of_cycle_n,
  output fas_pkg::fas_status_t   o_status
);
  import fas_pkg::*;

  // bus and control state
  logic              ph_write_q;
  logic [7:0]        ph_addr_q;
  logic [1:0]        ctrl_q;
  logic              srst_q;
  logic              cload_q;
  logic [11:0]       pre24_q;
  logic [11:0]       prelo_q;
  logic [31:0]       rdata_q;
  // datapath state
  logic [7:0]        shift_q;
  logic              alarm_q;
  logic              remote_q;
  logic [3:0]        lo_q;
  logic [3:0]        mid_q;
  logic [3:0]        hi_q;
  logic [3:0]        cycle_q;
  logic [3:0]        fl_q;
  logic [4:0]        tries_q;
  logic [4:0]        holdoff_q;
  logic              reset_flag_q;
  logic [3:0]        hist_q [DEPTH];
  logic [DEPTH-1:0]  sieve_q;
  logic              sf_q;
  // combinational terms
  logic              full_sel;
  logic              mode_24_channel;
  logic              alarm_raw_n;
  logic              counter_carry_out;
  logic              low_overflow;
  logic              acq_overflow;
  logic              early_load;
  logic              late_load;
  logic              short_window_input;
  logic              long_window_input;
  logic              operational_gate;
  logic              cycle_phase_output;
  logic              sieve_init_output;
  logic              write_pulse;
  logic              sieve_empty;
  logic              empty_load;
  logic [11:0]       preset;
  logic [3:0]        addr;
  logic [3:0]        hist;
  logic              predicted;
  logic              check;
  logic              writeback;
  logic              hist_bit;
  logic              in_frame;
  logic              run;

  // bus write and read decode
  logic              wr_ctrl;
  logic              wr_pre;
  logic              addr_take;

  assign addr_take   = i_hsel && i_hready && i_htrans[1];
  assign wr_ctrl     = ph_write_q && (ph_addr_q == FAS_OFF_CTRL);
  assign wr_pre      = ph_write_q && (ph_addr_q == FAS_OFF_PRESET);
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rdata_q;

  // address phase capture; zero-wait data phase
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ph_write_q <= 1'b0;
      ph_addr_q  <= 8'h00;
    end else begin
      ph_write_q <= addr_take && i_hwrite;
      ph_addr_q  <= i_haddr[7:0];
    end
  end

  // read data prepared during the address phase; unmapped words read zero
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_take && !i_hwrite) begin
      unique case (i_haddr[7:0])
        FAS_OFF_CTRL:   rdata_q <= {30'h0, ctrl_q};
        FAS_OFF_PRESET: rdata_q <= {4'h0, prelo_q, 4'h0, pre24_q};
        FAS_OFF_STATUS: rdata_q <= {20'h0, o_status};
        default:        rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // control and preset registers, one-shot strobes
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q  <= FAS_CTRL_RESET;
      srst_q  <= 1'b0;
      cload_q <= 1'b0;
      pre24_q <= FAS_PRE24_RESET;
      prelo_q <= FAS_PRELO_RESET;
    end else begin
      srst_q  <= wr_ctrl && i_hwdata[FAS_CTRL_SRST];
      cload_q <= wr_ctrl && i_hwdata[FAS_CTRL_CLOAD];
      if (wr_ctrl) begin
        ctrl_q <= {i_hwdata[FAS_CTRL_M24], i_hwdata[FAS_CTRL_FULL]};
      end
      if (wr_pre) begin
        pre24_q <= i_hwdata[FAS_PRE24_LSB +: 12];
        prelo_q <= i_hwdata[FAS_PRELO_LSB +: 12];
      end
    end
  end

  assign full_sel        = ctrl_q[FAS_CTRL_FULL];
  assign mode_24_channel = ctrl_q[FAS_CTRL_M24];

  // input shift register feeding the alarm detector
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_q <= 8'h00;
    end else begin
      shift_q <= {shift_q[6:0], i_recovered_serial_data};
    end
  end

  assign alarm_raw_n = (shift_q != FAS_ALARM_PAT);

  // alarm detector output, registered
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      alarm_q <= 1'b1;
    end else if (srst_q) begin
      alarm_q <= 1'b1;
    end else if (full_sel) begin
      alarm_q <= alarm_raw_n;
    end else if (i_channel_timing_bus) begin
      alarm_q <= alarm_raw_n;
    end
  end
  assign o_alarm_detect_n = alarm_q;

  // remote alarm line, held while out of frame
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      remote_q <= 1'b0;
    end else if (srst_q) begin
      remote_q <= 1'b0;
    end else if (in_frame) begin
      remote_q <= !alarm_q;
    end
  end
  assign o_remote_alarm = remote_q;

  // acquisition counter carries and windows
  // joint low overflow
  assign low_overflow       = (lo_q == 4'hf) && (mid_q == 4'hf);
  assign counter_carry_out  = (hi_q == 4'hf);
  assign acq_overflow       = low_overflow && counter_carry_out;
  assign late_load          = acq_overflow;
  assign early_load         = hi_q[3];
  assign short_window_input = (mid_q == 4'hf);
  assign long_window_input  = counter_carry_out;
  assign operational_gate   = short_window_input && long_window_input;
  assign o_operational_gate = operational_gate;
  assign preset             = mode_24_channel ? pre24_q : prelo_q;
  assign run                = (holdoff_q == 5'h00);
  assign addr               = lo_q;

  // acquisition counter with load logic
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      {hi_q, mid_q, lo_q} <= 12'h000;
      holdoff_q           <= 5'h00;
    end else if (srst_q) begin
      {hi_q, mid_q, lo_q} <= preset;
      holdoff_q           <= 5'h00;
    end else if (!run) begin
      holdoff_q <= holdoff_q - 5'h01;
      if (holdoff_q == 5'h01) begin
        {hi_q, mid_q, lo_q} <= preset;
      end
    end else if (late_load) begin
      {hi_q, mid_q, lo_q} <= preset;
      if (empty_load) begin
        holdoff_q <= FAS_SHIFT_CLOCKS;
      end
    end else begin
      lo_q <= lo_q + 4'h1;
      if (lo_q == 4'hf) begin
        mid_q <= mid_q + 4'h1;
      end
      if (low_overflow) begin
        hi_q <= hi_q + 4'h1;
      end
    end
  end

  // cycle phase decodes
  assign sieve_init_output  = (cycle_q < FAS_CYC_HIST_END);
  assign cycle_phase_output = cycle_q[2];
  assign o_end_of_cycle_n   = !(cycle_phase_output && operational_gate);
  assign write_pulse        = sieve_init_output && operational_gate && run;
  assign sieve_empty        = &sieve_q;
  assign empty_load         = sieve_empty && reset_flag_q;

  // cycle counter
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cycle_q <= 4'h0;
    end else if (srst_q) begin
      cycle_q <= 4'h0;
    end else if (late_load && run && empty_load) begin
      cycle_q <= 4'h0;
    end else if (cload_q) begin
      cycle_q <= FAS_CYC_CTRL_LOAD;
    end else if (acq_overflow && run) begin
      cycle_q <= cycle_q + 4'h1;
    end
  end

  // attempt count and reset flag
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      tries_q      <= 5'h00;
      reset_flag_q <= 1'b0;
    end else if (srst_q || (late_load && run && empty_load)) begin
      tries_q      <= 5'h00;
      reset_flag_q <= 1'b0;
    end else begin
      if (acq_overflow && run && !sieve_init_output && tries_q != FAS_ATTEMPTS) begin
        tries_q <= tries_q + 5'h01;
      end
      if (tries_q == FAS_ATTEMPTS && sieve_empty && operational_gate) begin
        reset_flag_q <= 1'b1;
      end
    end
  end

  // prediction from history
  assign hist      = hist_q[addr];
  assign predicted = FAS_PRED_VALID[hist] ? FAS_PRED_NEXT[hist] : i_recovered_serial_data;
  assign check     = mode_24_channel && (predicted == i_recovered_serial_data);
  assign writeback = check ? predicted : !predicted;
  assign hist_bit  = (cycle_q == 4'h0) ? !i_recovered_serial_data : writeback;

  // history storage on the falling edge
  generate
    for (genvar g = 0; g < DEPTH; g++) begin : g_hist
      always_ff @(negedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          hist_q[g] <= 4'h0;
        end else if (write_pulse && addr == 4'(g)) begin
          hist_q[g] <= {hist_q[g][2:0], hist_bit};
        end
      end
    end
  endgenerate

  // sieve memory
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sieve_q <= '1;
    end else if (write_pulse) begin
      sieve_q[addr] <= 1'b1;
    end else if (!sieve_init_output && operational_gate && run && check) begin
      sieve_q[addr] <= 1'b0;
    end
  end

  // superframe marker
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      sf_q <= 1'b0;
    end else begin
      sf_q <= (hist == FAS_SF_PATTERN);
    end
  end
  assign o_superframe_marker = sf_q;

  // frame-lock state counter
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      fl_q <= 4'h0;
    end else if (srst_q || (late_load && run && empty_load)) begin
      fl_q <= 4'h0;
    end else if (!fl_q[2] && low_overflow && !sieve_q[addr]) begin
      fl_q <= FAS_FL_LOCKED;
    end
  end
  assign in_frame = fl_q[2];

  // status snapshot
  always_comb begin
    o_status.frame_lock       = fl_q;
    o_status.cycle            = cycle_q;
    o_status.sieve_empty      = sieve_empty;
    o_status.reset_flag       = reset_flag_q;
    o_status.operational_gate = operational_gate;
    o_status.remote_alarm     = remote_q;
  end

  logic unused_ok;
  assign unused_ok = early_load ^ (|i_hsize) ^ (|i_haddr[31:8]) ^ i_htrans[0];

endmodule : fas_frame_sieve

// [common/fas_pkg.sv]
// Purpose: shared constants and types of the frame acquisition sieve
// Assumes: one 10 MHz clock, AHB-Lite register access with 32-bit words
// Notes:   register offsets are byte addresses of aligned words
package fas_pkg;

  // register map
  localparam logic [7:0]  FAS_OFF_CTRL      = 8'h00;
  localparam logic [7:0]  FAS_OFF_PRESET    = 8'h04;
  localparam logic [7:0]  FAS_OFF_STATUS    = 8'h08;

  // control register fields
  localparam int          FAS_CTRL_FULL     = 0;   // full_alarm_select
  localparam int          FAS_CTRL_M24      = 1;   // mode_24_channel
  localparam int          FAS_CTRL_SRST     = 2;   // self-clearing synchronous restart
  localparam int          FAS_CTRL_CLOAD    = 3;   // control-unit preset of cycle counter
  localparam logic [1:0]  FAS_CTRL_RESET    = 2'h2;

  // preset register: [11:0] 24-channel preset, [27:16] low-rate preset
  localparam int          FAS_PRE24_LSB     = 0;
  localparam int          FAS_PRELO_LSB     = 16;
  localparam logic [11:0] FAS_PRE24_RESET   = 12'h000;
  localparam logic [11:0] FAS_PRELO_RESET   = 12'h000;

  // remote alarm pattern, oldest bit in the msb
  localparam logic [7:0]  FAS_ALARM_PAT     = 8'h0f;

  // prediction table indexed by four history bits (oldest in the msb)
  localparam logic [15:0] FAS_PRED_VALID    = 16'h518a;
  localparam logic [15:0] FAS_PRED_NEXT     = 16'h010a;
  localparam logic [3:0]  FAS_SF_PATTERN    = 4'h3;

  // cycle counter states and search figures
  localparam logic [3:0]  FAS_CYC_CTRL_LOAD = 4'hb;
  localparam logic [3:0]  FAS_CYC_HIST_END  = 4'h4;
  localparam logic [3:0]  FAS_FL_LOCKED     = 4'h4;
  localparam logic [4:0]  FAS_ATTEMPTS      = 5'h10;
  localparam logic [4:0]  FAS_SHIFT_CLOCKS  = 5'h10;

  // status snapshot returned to software
  typedef struct packed {
    logic [3:0] frame_lock;
    logic [3:0] cycle;
    logic       sieve_empty;
    logic       reset_flag;
    logic       operational_gate;
    logic       remote_alarm;
  } fas_status_t;

endpackage : fas_pkg

// [verif/fas_sieve_checker.sv]
// Purpose: port-level checks of the frame acquisition sieve
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached to the design by the bind at the foot
`timescale 1ns/1ns
module fas_sieve_checker (
  input wire logic                 i_clock,
  input wire logic                 i_resetn,
  input wire logic                 i_channel_timing_bus,
  input wire logic                 o_alarm_detect_n,
  input wire logic                 o_remote_alarm,
  input wire logic                 o_operational_gate,
  input wire logic                 o_end_of_cycle_n,
  input wire fas_pkg::fas_status_t o_status
);
  import fas_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // gate stays up, or down, for sixteen counts
  sequence gate_run_s;
    o_operational_gate[*8] ##1 o_operational_gate[*8];
  endsequence
  sequence gate_gap_s;
    !o_operational_gate[*8] ##1 !o_operational_gate[*8];
  endsequence
  eoc_nand_a: assert property (
    o_end_of_cycle_n == !(o_status.cycle[2] && o_operational_gate))
    else $error("end of cycle is not the nand of phase and gate");
  gate_width_a: assert property (
    $rose(o_operational_gate) |-> gate_run_s)
    else $error("operational gate shorter than sixteen counts");
  gate_gap_a: assert property (
    $fell(o_operational_gate) |-> gate_gap_s)
    else $error("operational gate back too early");
  cycle_step_a: assert property (
    ($changed(o_status.cycle) && o_status.cycle != 4'h0 && o_status.cycle != FAS_CYC_CTRL_LOAD)
    |-> o_status.cycle == $past(o_status.cycle) + 4'h1)
    else $error("cycle counter moved by more than one state");
  remote_gate_a: assert property (
    $rose(o_remote_alarm) |-> $past(o_status.frame_lock[2]))
    else $error("remote alarm set while out of frame");
  status_remote_a: assert property (
    o_status.remote_alarm == o_remote_alarm)
    else $error("status remote alarm differs from the line");
  status_gate_a: assert property (
    o_status.operational_gate == o_operational_gate)
    else $error("status gate differs from the gate output");
  // gated mode holds a low alarm until the next channel end, so only a
  // channel end that sees the alarm low must bring it back high
  alarm_pulse_a: assert property (
    (!o_alarm_detect_n && i_channel_timing_bus) |=> o_alarm_detect_n)
    else $error("alarm detector low for more than one bit");
endmodule : fas_sieve_checker

bind fas_frame_sieve fas_sieve_checker fas_sieve_checker_i (
  .i_clock(i_clock), .i_resetn(i_resetn),
  .i_channel_timing_bus(i_channel_timing_bus), .o_alarm_detect_n(o_alarm_detect_n),
  .o_remote_alarm(o_remote_alarm), .o_operational_gate(o_operational_gate),
  .o_end_of_cycle_n(o_end_of_cycle_n), .o_status(o_status));

// [verif/fas_rx_model.sv]
// Purpose: receiver unit model sending serial bits to the sieve
// Assumes: one bit per rising edge of the recovered bit clock
// Notes:   line idles at ones between bursts, as a live link would
`timescale 1ns/1ns
module fas_rx_model (
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  input  wire logic       i_send,
  input  wire logic [7:0] i_pattern,
  output logic            o_data,
  output logic            o_busy
);
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  // burst of eight bits, oldest first, ones fill behind it
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      shift_q <= 8'hff;
      cnt_q   <= 4'h0;
    end else if (cnt_q != 4'h0) begin
      shift_q <= {shift_q[6:0], 1'b1};
      cnt_q   <= cnt_q - 4'h1;
    end else if (i_send) begin
      shift_q <= i_pattern;
      cnt_q   <= 4'h8;
    end
  end
  assign o_data = shift_q[7];
  assign o_busy = (cnt_q != 4'h0);
endmodule : fas_rx_model

// [verif/frame_acquisition_sieve_tb.sv]
// Purpose: self-checking bench of the frame acquisition sieve
// Assumes: AHB-Lite master tasks, receiver model on the serial line
// Notes:   window tests use a preset of f00, 256 counts per cycle state
`timescale 1ns/1ns
module frame_acquisition_sieve_tb;
  import fas_pkg::*;
  logic        i_clock, i_resetn, hsel, hwrite, chan, send, hready, hresp;
  logic        alarm_n, remote, marker, gate, eoc_n, data, seen;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  pat;
  fas_status_t status;
  int          miscompares, n_checks, n;

  always #50 i_clock = ~i_clock;

  fas_frame_sieve fas_frame_sieve_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_recovered_serial_data(data), .i_channel_timing_bus(chan),
    .o_alarm_detect_n(alarm_n), .o_remote_alarm(remote), .o_superframe_marker(marker),
    .o_operational_gate(gate), .o_end_of_cycle_n(eoc_n), .o_status(status));
  fas_rx_model fas_rx_model_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_send(send),
    .i_pattern(pat), .o_data(data), .o_busy());

  // verdict and end of run
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task check(input logic [31:0] s, input logic [31:0] e, input string msg);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, s, e);
    end
  endtask : check
  task hang(input string msg);
    miscompares++;
    $display("mismatch at %0t: no response in %s", $time, msg);
    finish_test();
  endtask : hang
  task wait_ready;
    int k;
    k = 0;
    @(posedge i_clock);
    while (hready !== 1'b1) begin
      if (++k > 20) hang("bus");
      @(posedge i_clock);
    end
  endtask : wait_ready
  // one single-word transfer, address then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clock);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus
  task send_pat(input logic [7:0] p, input int cyc);
    @(posedge i_clock);
    pat  <= p;
    send <= 1'b1;
    @(posedge i_clock);
    send <= 1'b0;
    seen = 1'b0;
    repeat (cyc) begin
      @(negedge i_clock);
      if (alarm_n === 1'b0) seen = 1'b1;
    end
  endtask : send_pat
  task wait_gate(input logic lvl, output int cnt);
    cnt = 0;
    while (gate !== lvl) begin
      @(negedge i_clock);
      if (++cnt > 5000) hang("gate");
    end
  endtask : wait_gate

  task t_reset;
    bus(1'b0, FAS_OFF_CTRL, 32'h0);
    check(rd, {30'h0, FAS_CTRL_RESET}, "ctrl reset");
    bus(1'b0, FAS_OFF_PRESET, 32'h0);
    check(rd, 32'h0, "preset reset");
    bus(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0, "unmapped read");
    bus(1'b0, FAS_OFF_STATUS, 32'h0);
    check(rd[11:4], 8'h00, "lock and cycle");
    check(rd[0], 1'b0, "remote in status");
    check(alarm_n, 1'b1, "alarm idle");
    check(marker, 1'b0, "marker idle");
    $display("test reset done");
  endtask : t_reset
  // raw detector and channel gating of the alarm
  task t_alarm;
    bus(1'b1, FAS_OFF_CTRL, 32'h3);
    send_pat(FAS_ALARM_PAT, 14);
    check(seen, 1'b1, "full alarm pass");
    check(remote, 1'b0, "remote out of frame");
    send_pat(8'h1f, 14);
    check(seen, 1'b0, "three zeros only");
    bus(1'b1, FAS_OFF_CTRL, 32'h2);
    send_pat(FAS_ALARM_PAT, 14);
    check(seen, 1'b0, "no channel end");
    @(posedge i_clock);
    chan <= 1'b1;
    send_pat(FAS_ALARM_PAT, 14);
    check(seen, 1'b1, "channel end alarm");
    @(posedge i_clock);
    chan <= 1'b0;
    $display("test alarm done");
  endtask : t_alarm
  // search window timing and cycle states
  task t_window;
    bus(1'b1, FAS_OFF_PRESET, 32'h0f00);
    check(hresp, 1'b0, "okay response");
    bus(1'b0, FAS_OFF_PRESET, 32'h0);
    check(rd, 32'h0f00, "preset readback");
    bus(1'b1, FAS_OFF_CTRL, 32'h6);
    wait_gate(1'b1, n);
    wait_gate(1'b0, n);
    check(n, 16, "gate width");
    wait_gate(1'b1, n);
    check(n, 240, "preset reload gap");
    bus(1'b0, FAS_OFF_STATUS, 32'h0);
    check(rd[7:4], 4'h1, "cycle after overflow");
    n = 0;
    while (eoc_n !== 1'b0) begin
      @(negedge i_clock);
      if (++n > 2000) hang("end of cycle");
    end
    check(status.cycle[2], 1'b1, "end of cycle phase");
    bus(1'b1, FAS_OFF_CTRL, 32'ha);
    bus(1'b0, FAS_OFF_STATUS, 32'h0);
    check(rd[7:4], FAS_CYC_CTRL_LOAD, "control load");
    // restart only outside the gate, so the gate is never cut short
    wait_gate(1'b0, n);
    bus(1'b1, FAS_OFF_CTRL, 32'h6);
    bus(1'b0, FAS_OFF_STATUS, 32'h0);
    check(rd[11:4], 8'h00, "restart state");
    check(remote, 1'b0, "restart alarm");
    $display("test window done");
  endtask : t_window

  initial begin
    i_clock = 1'b0;
    i_resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    chan = 1'b0;
    send = 1'b0;
    pat = 8'hff;
    miscompares = 0;
    n_checks = 0;
    repeat (4) @(posedge i_clock);
    i_resetn <= 1'b1;
    t_reset();
    t_alarm();
    t_window();
    finish_test();
  end
endmodule : frame_acquisition_sieve_tb
